// File: verilog/logic_op_pkg.sv
// shared constants and types of the bitwise logic execution unit
`default_nettype none
package logic_op_pkg;
	// opcode high nibbles per operation
	localparam logic [3:0] HI_AND = 4'h5;
	localparam logic [3:0] HI_OR = 4'h4;
	localparam logic [3:0] HI_XOR = 4'hB;
	// opcode low nibbles per operand form
	localparam logic [3:0] LO_WW = 4'h2;
	localparam logic [3:0] LO_WIW = 4'h3;
	localparam logic [3:0] LO_RR = 4'h4;
	localparam logic [3:0] LO_RIR = 4'h5;
	localparam logic [3:0] LO_RIM = 4'h6;
	localparam logic [3:0] LO_IRIM = 4'h7;
	// register field tag that selects a working register
	localparam logic [3:0] WORK_TAG = 4'hE;
	// execution lengths in cycles, start edge to done edge
	localparam logic [3:0] SHORT_CYC = 4'h6;
	localparam logic [3:0] LONG_CYC = 4'hA;

	typedef enum logic [1:0] {OP_AND, OP_OR, OP_XOR} logic_op_e;
	typedef enum logic [2:0] {ST_IDLE, ST_SPTR, ST_SRD, ST_DPTR, ST_DRD, ST_WAIT} state_e;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] first;
		logic [7:0] second;
	} instr_s;

	typedef struct packed {
		logic carry;
		logic zero;
		logic sign;
		logic overflow;
		logic decimal_adjust;
		logic half_carry;
	} flags_s;

	typedef struct packed {
		state_e state;
		logic_op_e op;
		logic [3:0] cnt;
		logic [3:0] last;
		logic [7:0] src_val;
		logic [7:0] dst_addr;
		logic [7:0] rd_addr;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic done;
		logic busy;
		flags_s flags;
	} core_s;

	localparam core_s CORE_RST = '0;
endpackage
`default_nettype wire

// File: verilog/logic_op_unit.sv
// bitwise and, or, exclusive or execution unit with operand decode and flags
`default_nettype none
// What this block does
// - and gives 1 only where both operand bits are 1
// - or gives 1 where either operand bit is 1
// - exclusive or gives 1 where operand bits differ
// - result goes to destination; source location is never written
// - zero flag set when result is zero, cleared otherwise
// - sign flag takes result bit 7; overflow flag forced to 0
// - working forms take 6 cycles, all other forms take 10
// - and opcodes have high nibble 5; low nibble 2..7 picks form
// - or opcodes have high nibble 4, same form mapping
// - exclusive or opcodes have high nibble B, same form mapping
// - register field with high nibble E names a working register
module logic_op_unit (
	input wire logic sys_clk_i, // core clock
	input wire logic sys_rst_i, // asynchronous reset, active high
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic start_i, // request to execute the held instruction
	input wire logic_op_pkg::instr_s instr_i, // opcode and two operand bytes
	input wire logic [3:0] work_base_i, // upper address nibble of working registers
	input wire logic [7:0] rd_data_i, // register file data at rd_addr_o
	input wire logic_op_pkg::flags_s flags_i, // current core flags
	output logic busy_o, // instruction in progress
	output logic done_o, // one-cycle pulse at completion
	output logic [7:0] rd_addr_o, // register file read address
	output logic wr_en_o, // one-cycle register file write strobe
	output logic [7:0] wr_addr_o, // register file write address
	output logic [7:0] wr_data_o, // register file write data
	output logic_op_pkg::flags_s flags_o // flags after the last operation
);
	logic_op_pkg::core_s st_r;
	logic_op_pkg::core_s st_nxt;
	logic [3:0] op_hi;
	logic [3:0] op_lo;
	logic hi_ok;
	logic lo_ok;
	logic accept;
	logic [7:0] result;

	// full register field to address, working register tag expanded
	function automatic logic [7:0] reg_map(input logic [7:0] f, input logic [3:0] base);
		reg_map = (f[7:4] == logic_op_pkg::WORK_TAG) ? {base, f[3:0]} : f;
	endfunction

	// opcode legality and request acceptance
	assign op_hi = instr_i.opcode[7:4];
	assign op_lo = instr_i.opcode[3:0];
	assign hi_ok = (op_hi == logic_op_pkg::HI_AND) || (op_hi == logic_op_pkg::HI_OR) ||
		(op_hi == logic_op_pkg::HI_XOR);
	assign lo_ok = (op_lo >= logic_op_pkg::LO_WW) && (op_lo <= logic_op_pkg::LO_IRIM);
	assign accept = start_i && (st_r.state == logic_op_pkg::ST_IDLE) && hi_ok && lo_ok;

	// bitwise function on source and destination data
	always_comb begin
		unique case (st_r.op)
			logic_op_pkg::OP_AND: result = st_r.src_val & rd_data_i;
			logic_op_pkg::OP_OR: result = st_r.src_val | rd_data_i;
			logic_op_pkg::OP_XOR: result = st_r.src_val ^ rd_data_i;
			default: result = 8'h00;
		endcase
	end

	// sequencer: operand fetch, hold to the cycle count, then write back
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.wr_en = 1'b0;
		if (st_r.state != logic_op_pkg::ST_IDLE) begin
			st_nxt.cnt = st_r.cnt + 4'h1;
		end
		unique case (st_r.state)
			logic_op_pkg::ST_IDLE: begin
				if (accept) begin
					st_nxt.busy = 1'b1;
					st_nxt.cnt = 4'h1;
					if (op_hi == logic_op_pkg::HI_AND) begin
						st_nxt.op = logic_op_pkg::OP_AND;
					end else if (op_hi == logic_op_pkg::HI_OR) begin
						st_nxt.op = logic_op_pkg::OP_OR;
					end else begin
						st_nxt.op = logic_op_pkg::OP_XOR;
					end
					if (op_lo == logic_op_pkg::LO_WW || op_lo == logic_op_pkg::LO_WIW) begin
						st_nxt.last = logic_op_pkg::SHORT_CYC - 4'h1;
					end else begin
						st_nxt.last = logic_op_pkg::LONG_CYC - 4'h1;
					end
					unique case (op_lo)
						logic_op_pkg::LO_WW: begin
							st_nxt.dst_addr = {work_base_i, instr_i.first[7:4]};
							st_nxt.rd_addr = {work_base_i, instr_i.first[3:0]};
							st_nxt.state = logic_op_pkg::ST_SRD;
						end
						logic_op_pkg::LO_WIW: begin
							st_nxt.dst_addr = {work_base_i, instr_i.first[7:4]};
							st_nxt.rd_addr = {work_base_i, instr_i.first[3:0]};
							st_nxt.state = logic_op_pkg::ST_SPTR;
						end
						logic_op_pkg::LO_RR: begin
							st_nxt.rd_addr = reg_map(instr_i.first, work_base_i);
							st_nxt.dst_addr = reg_map(instr_i.second, work_base_i);
							st_nxt.state = logic_op_pkg::ST_SRD;
						end
						logic_op_pkg::LO_RIR: begin
							st_nxt.rd_addr = reg_map(instr_i.first, work_base_i);
							st_nxt.dst_addr = reg_map(instr_i.second, work_base_i);
							st_nxt.state = logic_op_pkg::ST_SPTR;
						end
						logic_op_pkg::LO_RIM: begin
							st_nxt.dst_addr = reg_map(instr_i.first, work_base_i);
							st_nxt.rd_addr = reg_map(instr_i.first, work_base_i);
							st_nxt.src_val = instr_i.second;
							st_nxt.state = logic_op_pkg::ST_DRD;
						end
						default: begin
							st_nxt.rd_addr = reg_map(instr_i.first, work_base_i);
							st_nxt.src_val = instr_i.second;
							st_nxt.state = logic_op_pkg::ST_DPTR;
						end
					endcase
				end
			end
			// source pointer read, then fetch the source itself
			logic_op_pkg::ST_SPTR: begin
				st_nxt.rd_addr = rd_data_i;
				st_nxt.state = logic_op_pkg::ST_SRD;
			end
			logic_op_pkg::ST_SRD: begin
				st_nxt.src_val = rd_data_i;
				st_nxt.rd_addr = st_r.dst_addr;
				st_nxt.state = logic_op_pkg::ST_DRD;
			end
			// destination pointer read for the indirect literal form
			logic_op_pkg::ST_DPTR: begin
				st_nxt.dst_addr = rd_data_i;
				st_nxt.rd_addr = rd_data_i;
				st_nxt.state = logic_op_pkg::ST_DRD;
			end
			logic_op_pkg::ST_DRD: begin
				st_nxt.wr_data = result;
				st_nxt.state = logic_op_pkg::ST_WAIT;
			end
			logic_op_pkg::ST_WAIT: begin
				if (st_r.cnt == st_r.last) begin
					st_nxt.wr_en = 1'b1;
					st_nxt.wr_addr = st_r.dst_addr;
					st_nxt.done = 1'b1;
					st_nxt.busy = 1'b0;
					st_nxt.flags.zero = (st_r.wr_data == 8'h00);
					st_nxt.flags.sign = st_r.wr_data[7];
					st_nxt.flags.overflow = 1'b0;
					st_nxt.flags.carry = flags_i.carry;
					st_nxt.flags.decimal_adjust = flags_i.decimal_adjust;
					st_nxt.flags.half_carry = flags_i.half_carry;
					st_nxt.state = logic_op_pkg::ST_IDLE;
				end
			end
			default: st_nxt.state = logic_op_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= logic_op_pkg::CORE_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign busy_o = st_r.busy;
	assign done_o = st_r.done;
	assign rd_addr_o = st_r.rd_addr;
	assign wr_en_o = st_r.wr_en;
	assign wr_addr_o = st_r.wr_addr;
	assign wr_data_o = st_r.wr_data;
	assign flags_o = st_r.flags;

	// helper: operands as seen when the result was formed
	logic [7:0] chk_src_r;
	logic [7:0] chk_dst_r;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chk_src_r <= 8'h00;
			chk_dst_r <= 8'h00;
		end else if (ce_i && st_r.state == logic_op_pkg::ST_DRD) begin
			chk_src_r <= st_r.src_val;
			chk_dst_r <= rd_data_i;
		end
	end

	property p_and_result;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		done_o && st_r.op == logic_op_pkg::OP_AND |-> wr_data_o == (chk_src_r & chk_dst_r);
	endproperty
	a_and_result: assert property (p_and_result) else $error("and result wrong");

	property p_or_result;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		done_o && st_r.op == logic_op_pkg::OP_OR |-> wr_data_o == (chk_src_r | chk_dst_r);
	endproperty
	a_or_result: assert property (p_or_result) else $error("or result wrong");

	property p_xor_result;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		done_o && st_r.op == logic_op_pkg::OP_XOR |-> wr_data_o == (chk_src_r ^ chk_dst_r);
	endproperty
	a_xor_result: assert property (p_xor_result) else $error("xor result wrong");

	property p_single_write;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		wr_en_o |-> done_o && wr_addr_o == st_r.dst_addr;
	endproperty
	a_single_write: assert property (p_single_write) else $error("stray write");

	property p_zero_flag;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		done_o |-> flags_o.zero == (wr_data_o == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

	property p_sign_ovf;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		done_o |-> flags_o.sign == wr_data_o[7] && !flags_o.overflow;
	endproperty
	a_sign_ovf: assert property (p_sign_ovf) else $error("sign or overflow wrong");

	property p_keep_flags;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		$rose(done_o) |-> flags_o.carry == $past(flags_i.carry) &&
			flags_o.half_carry == $past(flags_i.half_carry) &&
			flags_o.decimal_adjust == $past(flags_i.decimal_adjust);
	endproperty
	a_keep_flags: assert property (p_keep_flags) else $error("untouched flag changed");

	property p_short_time;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_lo <= logic_op_pkg::LO_WIW |-> ##1 !done_o [*5] ##1 done_o;
	endproperty
	a_short_time: assert property (p_short_time) else $error("short form not 6 cycles");

	property p_long_time;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_lo >= logic_op_pkg::LO_RR |-> ##9 !done_o ##1 done_o;
	endproperty
	a_long_time: assert property (p_long_time) else $error("long form not 10 cycles");

	property p_decode_and;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_hi == logic_op_pkg::HI_AND |=> st_r.op == logic_op_pkg::OP_AND && busy_o;
	endproperty
	a_decode_and: assert property (p_decode_and) else $error("and decode wrong");

	property p_decode_xor;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_hi == logic_op_pkg::HI_XOR |=> st_r.op == logic_op_pkg::OP_XOR;
	endproperty
	a_decode_xor: assert property (p_decode_xor) else $error("xor decode wrong");

	property p_work_map;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && (op_lo == logic_op_pkg::LO_RR || op_lo == logic_op_pkg::LO_RIR) &&
			instr_i.second[7:4] == logic_op_pkg::WORK_TAG
		|=> st_r.dst_addr == {$past(work_base_i), $past(instr_i.second[3:0])} &&
			rd_addr_o == reg_map($past(instr_i.first), $past(work_base_i));
	endproperty
	a_work_map: assert property (p_work_map) else $error("operand mapping wrong");

	property p_decode_or;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_hi == logic_op_pkg::HI_OR |=> st_r.op == logic_op_pkg::OP_OR && busy_o;
	endproperty
	a_decode_or: assert property (p_decode_or) else $error("or decode wrong");

	// operand byte placement per form
	property p_work_pair;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_lo == logic_op_pkg::LO_WW
		|=> st_r.dst_addr == {$past(work_base_i), $past(instr_i.first[7:4])} &&
			rd_addr_o == {$past(work_base_i), $past(instr_i.first[3:0])};
	endproperty
	a_work_pair: assert property (p_work_pair) else $error("working pair placement wrong");

	property p_reg_src;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_lo == logic_op_pkg::LO_RR && instr_i.first[7:4] != logic_op_pkg::WORK_TAG
		|=> rd_addr_o == $past(instr_i.first);
	endproperty
	a_reg_src: assert property (p_reg_src) else $error("source byte placement wrong");

	property p_literal_pair;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		accept && op_lo == logic_op_pkg::LO_RIM && instr_i.first[7:4] != logic_op_pkg::WORK_TAG
		|=> st_r.dst_addr == $past(instr_i.first) && st_r.src_val == $past(instr_i.second);
	endproperty
	a_literal_pair: assert property (p_literal_pair) else $error("literal placement wrong");

	// the completion cycle is already idle, so a new request can be taken there
	property p_done_idle;
		@(posedge sys_clk_i iff ce_i) disable iff (sys_rst_i)
		done_o |-> !busy_o && st_r.state == logic_op_pkg::ST_IDLE;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("not idle at completion");
endmodule
`default_nettype wire

// File: sim/tb_logic_op_unit.sv
// self-checking testbench of the bitwise logic execution unit
`default_nettype none
module tb_logic_op_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic start_i = 1'b0;
	logic_op_pkg::instr_s instr_i = '0;
	logic [3:0] work_base_i = 4'h1;
	logic [7:0] rd_data_i;
	logic_op_pkg::flags_s flags_i = '0;
	logic busy_o;
	logic done_o;
	logic wr_en_o;
	logic [7:0] rd_addr_o;
	logic [7:0] wr_addr_o;
	logic [7:0] wr_data_o;
	logic_op_pkg::flags_s flags_o;
	logic [7:0] mem [256];
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;

	// register file model with a combinational read port
	assign rd_data_i = mem[rd_addr_o];

	logic_op_unit dut (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.start_i(start_i),
		.instr_i(instr_i),
		.work_base_i(work_base_i),
		.rd_data_i(rd_data_i),
		.flags_i(flags_i),
		.busy_o(busy_o),
		.done_o(done_o),
		.rd_addr_o(rd_addr_o),
		.wr_en_o(wr_en_o),
		.wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o),
		.flags_o(flags_o)
	);

	// 250 MHz core clock
	always #2 sys_clk_i = ~sys_clk_i;

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// expected result of operation k on destination and source bytes
	function automatic logic [7:0] lop(input int k, input logic [7:0] d, input logic [7:0] s);
		case (k)
			0: return d & s;
			1: return d | s;
			default: return d ^ s;
		endcase
	endfunction

	function automatic logic [3:0] hi(input int k);
		case (k)
			0: return logic_op_pkg::HI_AND;
			1: return logic_op_pkg::HI_OR;
			default: return logic_op_pkg::HI_XOR;
		endcase
	endfunction

	// count edges after the taking edge up to the one that launches done (sampled high one later)
	task automatic wait_done(input logic hold, input int stall, output int c);
		c = 0;
		do begin
			@(posedge sys_clk_i);
			c++;
			start_i <= hold;
			ce_i <= !(c >= 2 && c < 2 + stall);
			#1;
		end while (done_o !== 1'b1 && c < 40);
	endtask

	// issue one instruction and judge timing, write-back and flags
	task automatic exec(input int k, input logic [3:0] lo, input logic [7:0] f, input logic [7:0] s,
		input logic [7:0] ea, input logic [7:0] ed, input int n, input int stall);
		int c;
		logic_op_pkg::flags_s ef;
		ef = k[0] ? 6'h2B : 6'h14;
		@(posedge sys_clk_i);
		start_i <= 1'b1;
		instr_i <= {hi(k), lo, f, s};
		flags_i <= ef;
		@(posedge sys_clk_i);
		start_i <= 1'b0;
		wait_done(1'b0, stall, c);
		check("latency", 8'(c), 8'(n + stall - 1));
		check("write strobe", {7'h00, wr_en_o}, 8'h01);
		check("write address", wr_addr_o, ea);
		check("result", wr_data_o, ed);
		ef.zero = (ed == 8'h00);
		ef.sign = ed[7];
		ef.overflow = 1'b0;
		check("flags", {2'h0, flags_o}, {2'h0, ef});
	endtask

	// working register forms for every operation
	task automatic t_working;
		for (int k = 0; k < 3; k++) begin
			exec(k, logic_op_pkg::LO_WW, 8'h1E, 8'h00, 8'h11, lop(k, 8'h34, 8'h4D), 6, 0);
			exec(k, logic_op_pkg::LO_WIW, 8'h4D, 8'h00, 8'h14, lop(k, 8'hF9, 8'h6A), 6, 0);
		end
		$display("end of working forms");
	endtask

	// full register, indirect and literal forms, with enable stalls
	task automatic t_full;
		@(posedge sys_clk_i);
		work_base_i <= 4'h2;
		for (int k = 0; k < 3; k++) begin
			exec(k, logic_op_pkg::LO_RR, 8'h42, 8'h3A, 8'h3A, lop(k, 8'hF5, 8'h0A), 10, k);
			exec(k, logic_op_pkg::LO_RIR, 8'h45, 8'hE5, 8'h25, lop(k, 8'hF0, 8'hF5), 10, 0);
			exec(k, logic_op_pkg::LO_RIM, 8'h7A, 8'hF0, 8'h7A, lop(k, 8'hF7, 8'hF0), 10, 0);
			exec(k, logic_op_pkg::LO_IRIM, 8'hE3, 8'h05, 8'h3E, lop(k, 8'hEC, 8'h05), 10, 0);
		end
		$display("end of register forms");
	endtask

	// request held through busy is ignored, then taken on the done edge
	task automatic t_back;
		int c;
		@(posedge sys_clk_i);
		start_i <= 1'b1;
		instr_i <= {logic_op_pkg::HI_AND, logic_op_pkg::LO_RR, 8'h42, 8'h3A};
		@(posedge sys_clk_i);
		instr_i <= {logic_op_pkg::HI_OR, logic_op_pkg::LO_RR, 8'h42, 8'h3A};
		wait_done(1'b1, 0, c);
		// first count starts after the taking edge, the second at its own taking edge
		check("first latency", 8'(c), 8'h09);
		check("first result", wr_data_o, 8'h00);
		wait_done(1'b0, 0, c);
		check("second latency", 8'(c), 8'h0A);
		check("second result", wr_data_o, 8'hFF);
		$display("end of back to back");
	endtask

	// opcodes outside the three operations or the six forms start nothing
	task automatic t_refuse;
		logic seen;
		seen = 1'b0;
		@(posedge sys_clk_i);
		start_i <= 1'b1;
		instr_i <= 24'h581E00;
		@(posedge sys_clk_i);
		instr_i <= 24'h621E00;
		@(posedge sys_clk_i);
		instr_i <= 24'hB11E00;
		@(posedge sys_clk_i);
		start_i <= 1'b0;
		repeat (12) begin
			@(posedge sys_clk_i);
			#1;
			if (busy_o !== 1'b0 || done_o !== 1'b0) seen = 1'b1;
		end
		check("refused start", {7'h00, seen}, 8'h00);
		$display("end of refused opcodes");
	endtask

	// register file contents, reset, then the scenarios
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		mem[8'h11] = 8'h34;
		mem[8'h1E] = 8'h4D;
		mem[8'h14] = 8'hF9;
		mem[8'h1D] = 8'h7B;
		mem[8'h7B] = 8'h6A;
		mem[8'h42] = 8'h0A;
		mem[8'h3A] = 8'hF5;
		mem[8'h45] = 8'h3A;
		mem[8'h25] = 8'hF0;
		mem[8'h7A] = 8'hF7;
		mem[8'h23] = 8'h3E;
		mem[8'h3E] = 8'hEC;
		// first edge under reset clears the state, the second releases it
		@(posedge sys_clk_i);
		#1;
		check("reset outputs", {5'h00, busy_o, done_o, wr_en_o}, 8'h00);
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		t_working();
		t_full();
		t_back();
		t_refuse();
		wrap_up();
	end
endmodule
`default_nettype wire
